// File: design/lbr_pkg.sv
package lbr_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] LBR_ADDR_TXFS   = 8'h44;
	localparam logic [7:0] LBR_ADDR_BRINFO = 8'h48;
	localparam logic [7:0] LBR_ADDR_BUS_RESET_ERROR_REPORT  = 8'h4c;

	// ==========================================================
	// field positions in tx_fifo_status_size
	localparam int LBR_TX_FULL_BIT   = 0;
	localparam int LBR_TX_AFULL_BIT  = 1;
	localparam int LBR_TX_FOUR_BIT   = 4;
	localparam int LBR_TX_AEMPTY_BIT = 14;
	localparam int LBR_TX_EMPTY_BIT  = 15;
	localparam int LBR_TX_FLUSH_BIT  = 17;
	localparam int LBR_TX_CAP_LSB    = 25;

	// ==========================================================
	// field positions in bus_reset_node_info
	localparam int LBR_BUS_NUMBER_LSB  = 0;
	localparam int LBR_NODE_NUMBER_LSB = 10;
	localparam int LBR_VALID_BIT   = 16;
	localparam int LBR_NCOUNT_LSB  = 18;
	localparam int LBR_ROOT_BIT    = 24;
	localparam int LBR_RESOLVER_NODE_ID_LSB   = 26;

	// ==========================================================
	// field positions in bus_reset_error_report
	localparam int LBR_ECLR_BIT  = 0;
	localparam int LBR_ECODE_LSB = 1;

	// ==========================================================
	// reset values
	localparam logic [6:0] LBR_TX_CAP_RST  = 7'h14;
	localparam logic [9:0] LBR_BUS_NUMBER_RST  = 10'h3ff;
	localparam logic [5:0] LBR_NODE_NUMBER_RST = 6'h3f;
	localparam logic [5:0] LBR_NCOUNT_RST  = 6'h01;
	localparam logic [5:0] LBR_RESOLVER_NODE_ID_RST   = 6'h3f;

	// ==========================================================
	// free-space and fill-level thresholds for the occupancy flags
	localparam logic [6:0] LBR_FREE_ONE  = 7'h01;
	localparam logic [6:0] LBR_FREE_FOUR = 7'h04;
	localparam logic [6:0] LBR_USED_ONE  = 7'h01;

	// ==========================================================
	// self-ID error codes
	typedef enum logic [3:0]
	{
		LBR_ERR_NONE       = 4'h0,
		LBR_ERR_CHILD      = 4'h1,
		LBR_ERR_PHYID      = 4'h2,
		LBR_ERR_NOT_INV2   = 4'h3,
		LBR_ERR_JUMP_TWO   = 4'h4,
		LBR_ERR_JUMP_MORE  = 4'h5,
		LBR_ERR_ID_DIFFER  = 4'h6,
		LBR_ERR_NOT_INV    = 4'h7,
		LBR_ERR_BAD_QUAD   = 4'h8
	} lbr_err_type;

endpackage

// File: design/lbr_regs.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - full flag reads 1 exactly when no quadlet of storage is free
// R2 - almost-full flag reads 1 when exactly one quadlet is free
// R3 - four-free flag reads 1 when four or more quadlets are free
// R4 - almost-empty flag reads 1 when exactly one quadlet is held
// R5 - empty flag reads 1 when empty; set by every reset
// R6 - occupancy flags writable only while diagnostic write enable is set
// R7 - fifo status flags return to empty on power-up, bus and software reset; capacity resets on power-up/software reset only
// R8 - writing 1 to flush discards fifo contents; bit self-clears
// R9 - seven-bit capacity field host-writable; resets to default size
// R10 - ten-bit bus number host-writable; default on power-up/software reset
// R11 - node number host-writable; loads phy node id on self-ID status
// R12 - node number goes to all ones on bus-reset status and resets
// R13 - valid flag set once node count and resolver id are valid
// R14 - node count read-only; set to one on every reset
// R15 - root bit mirrors local phy root state
// R16 - resolver id read-only; all ones on every reset
// R17 - writing 1 to error clear zeroes the error code; self-clears
// R18 - codes 0, 1 child ports, 2 phy id mismatch
// R19 - codes 3 second quadlet, 7 not inverses, 8 bad quadlet
// R20 - codes 4 jump two, 5 jump three or more, 6 ids differ
// R21 - detected error code latched until host clear or reset
// R22 - writes to read-only fields ignored without diagnostic enable
module lbr_regs
	import lbr_pkg::*;
#(
	parameter int CAP_W = 7
)
(
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             bus_reset_evt,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	input  wire logic             link_diagnostics_write_enable,
	input  wire logic [CAP_W-1:0] fifo_used,
	output logic                  tx_fifo_flush,
	output logic      [CAP_W-1:0] tx_fifo_capacity,
	input  wire logic             phy_selfid_evt,
	input  wire logic [5:0]       phy_node_id,
	input  wire logic             phy_busreset_evt,
	input  wire logic             topo_valid_evt,
	input  wire logic [5:0]       topo_node_count,
	input  wire logic [5:0]       topo_resolver_id,
	input  wire logic             phy_root,
	input  wire logic             selfid_err_evt,
	input  wire logic [3:0]       selfid_err_in,
	output logic      [9:0]       bus_number,
	output logic      [5:0]       node_number,
	output logic      [3:0]       selfid_error_code
);

	// ==========================================================
	// decode
	logic             wr_txfs;
	logic             wr_brinfo;
	logic             wr_bus_reset_error_report;
	logic [CAP_W-1:0] free_q;
	logic [4:0]       flags_d;
	logic [4:0]       flags_q;
	logic             link_diagnostics_ovr_q;
	logic             count_resolver_valid_q;
	logic [5:0]       node_count_q;
	logic [5:0]       resolver_node_id_q;
	logic             root_q;
	logic [31:0]      txfs_v;
	logic [31:0]      brinfo_v;
	logic [31:0]      bus_reset_error_report_v;

	assign wr_txfs   = reg_wr && (reg_addr == LBR_ADDR_TXFS);
	assign wr_brinfo = reg_wr && (reg_addr == LBR_ADDR_BRINFO);
	assign wr_bus_reset_error_report  = reg_wr && (reg_addr == LBR_ADDR_BUS_RESET_ERROR_REPORT);

	// free quadlets left in the transmit fifo
	always_comb
	begin
		if (fifo_used >= tx_fifo_capacity)
			free_q = '0;
		else
			free_q = tx_fifo_capacity - fifo_used;
	end

	// ==========================================================
	// occupancy flags, order: full, afull, four, aempty, empty
	always_comb
	begin
		flags_d[0] = (free_q == '0);                          // R1
		flags_d[1] = (free_q == LBR_FREE_ONE);                // R2
		flags_d[2] = (free_q >= LBR_FREE_FOUR);               // R3
		flags_d[3] = (fifo_used == LBR_USED_ONE);             // R4
		flags_d[4] = (fifo_used == '0);                       // R5
	end

	// flags track the fifo; a diagnostic write holds until enable drops and the image differs from the fifo flags
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || bus_reset_evt || tx_fifo_flush)
		begin
			flags_q    <= 5'b1_0000;                          // R5 R7
			link_diagnostics_ovr_q <= 1'b0;
		end
		else if (wr_txfs && link_diagnostics_write_enable)                // R6 R22
		begin
			flags_q    <= {reg_wdata[LBR_TX_EMPTY_BIT],
				reg_wdata[LBR_TX_AEMPTY_BIT],
				reg_wdata[LBR_TX_FOUR_BIT],
				reg_wdata[LBR_TX_AFULL_BIT],
				reg_wdata[LBR_TX_FULL_BIT]};
			link_diagnostics_ovr_q <= 1'b1;
		end
		else if (!link_diagnostics_ovr_q || (flags_d != flags_q && !link_diagnostics_write_enable))
		begin
			flags_q    <= flags_d;
			link_diagnostics_ovr_q <= 1'b0;
		end
	end

	// ==========================================================
	// flush pulse and capacity
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || bus_reset_evt)
			tx_fifo_flush <= 1'b0;                            // R7
		else
			tx_fifo_flush <= wr_txfs && reg_wdata[LBR_TX_FLUSH_BIT]; // R8
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			tx_fifo_capacity <= CAP_W'(LBR_TX_CAP_RST);       // R9
		else if (wr_txfs)
			tx_fifo_capacity <= reg_wdata[LBR_TX_CAP_LSB +: CAP_W]; // R9
	end

	// ==========================================================
	// bus number and node number
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			bus_number <= LBR_BUS_NUMBER_RST;                     // R10
		else if (wr_brinfo)
			bus_number <= reg_wdata[LBR_BUS_NUMBER_LSB +: 10];    // R10
	end

	// phy events win over a host write in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || phy_busreset_evt)
			node_number <= LBR_NODE_NUMBER_RST;                   // R12
		else if (phy_selfid_evt)
			node_number <= phy_node_id;                       // R11
		else if (wr_brinfo)
			node_number <= reg_wdata[LBR_NODE_NUMBER_LSB +: 6];   // R11
	end

	// ==========================================================
	// topology status, read-only
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || bus_reset_evt)
		begin
			count_resolver_valid_q <= 1'b0;
			node_count_q           <= LBR_NCOUNT_RST;         // R14
			resolver_node_id_q     <= LBR_RESOLVER_NODE_ID_RST;          // R16
		end
		else if (topo_valid_evt)
		begin
			count_resolver_valid_q <= 1'b1;                   // R13
			node_count_q           <= topo_node_count;        // R14
			resolver_node_id_q     <= topo_resolver_id;       // R16
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			root_q <= 1'b0;
		else
			root_q <= phy_root;                               // R15
	end

	// ==========================================================
	// self-ID error code: set wins over clear
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			selfid_error_code <= LBR_ERR_NONE;
		else if (selfid_err_evt)
			selfid_error_code <= selfid_err_in;               // R18 R19 R20 R21
		else if (wr_bus_reset_error_report && reg_wdata[LBR_ECLR_BIT])
			selfid_error_code <= LBR_ERR_NONE;                // R17
	end

	// ==========================================================
	// read path, data one cycle after the strobe
	always_comb
	begin
		txfs_v = '0;
		txfs_v[LBR_TX_FULL_BIT]   = flags_q[0];
		txfs_v[LBR_TX_AFULL_BIT]  = flags_q[1];
		txfs_v[LBR_TX_FOUR_BIT]   = flags_q[2];
		txfs_v[LBR_TX_AEMPTY_BIT] = flags_q[3];
		txfs_v[LBR_TX_EMPTY_BIT]  = flags_q[4];
		txfs_v[LBR_TX_CAP_LSB +: CAP_W] = tx_fifo_capacity;
		brinfo_v = '0;
		brinfo_v[LBR_BUS_NUMBER_LSB +: 10] = bus_number;
		brinfo_v[LBR_NODE_NUMBER_LSB +: 6] = node_number;
		brinfo_v[LBR_VALID_BIT]        = count_resolver_valid_q;
		brinfo_v[LBR_NCOUNT_LSB +: 6]  = node_count_q;
		brinfo_v[LBR_ROOT_BIT]         = root_q;
		brinfo_v[LBR_RESOLVER_NODE_ID_LSB +: 6]   = resolver_node_id_q;
		bus_reset_error_report_v = '0;
		bus_reset_error_report_v[LBR_ECODE_LSB +: 4] = selfid_error_code;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				LBR_ADDR_TXFS:   reg_rdata <= txfs_v;
				LBR_ADDR_BRINFO: reg_rdata <= brinfo_v;
				LBR_ADDR_BUS_RESET_ERROR_REPORT:  reg_rdata <= bus_reset_error_report_v;
				default:         reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

	// ==========================================================
	// checks
	chk_flush_pulse_once: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
		tx_fifo_flush |=> !tx_fifo_flush)
		else $error("flush stayed high");
	chk_error_clear_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // R17
		(wr_bus_reset_error_report && reg_wdata[LBR_ECLR_BIT] && !selfid_err_evt)
		|=> selfid_error_code == LBR_ERR_NONE)
		else $error("error code not cleared");
	chk_error_code_latch: assert property (@(posedge sys_clk) disable iff (sys_rst) // R21
		selfid_err_evt |=> selfid_error_code == $past(selfid_err_in))
		else $error("error code not latched");
	chk_node_busreset_ones: assert property (@(posedge sys_clk) disable iff (sys_rst) // R12
		phy_busreset_evt |=> node_number == LBR_NODE_NUMBER_RST)
		else $error("node number not all ones");
	chk_node_selfid_load: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
		(phy_selfid_evt && !phy_busreset_evt) |=> node_number == $past(phy_node_id))
		else $error("node number not loaded");
	chk_empty_after_busreset: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
		bus_reset_evt |=> flags_q == 5'b1_0000)
		else $error("flags wrong after bus reset");
	chk_full_tracks_fifo: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
		(!link_diagnostics_write_enable && !wr_txfs && !bus_reset_evt && !tx_fifo_flush
		&& !link_diagnostics_ovr_q) |=> flags_q[0] == $past(free_q == '0))
		else $error("full flag wrong");
	chk_resolver_node_id_busreset_ones: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
		bus_reset_evt |=> (resolver_node_id_q == LBR_RESOLVER_NODE_ID_RST)
		&& (node_count_q == LBR_NCOUNT_RST) && !count_resolver_valid_q)
		else $error("topology not reset");
	chk_read_data_slot: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == LBR_ADDR_BUS_RESET_ERROR_REPORT)
		|=> reg_rdata[LBR_ECODE_LSB +: 4] == $past(selfid_error_code))
		else $error("read data wrong");

	// ==========================================================
	// occupancy flags follow the fifo when nothing overrides them
	chk_afull_tracks: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
		(!link_diagnostics_write_enable && !wr_txfs && !bus_reset_evt && !tx_fifo_flush
		&& !link_diagnostics_ovr_q) |=> flags_q[1] == $past(free_q == LBR_FREE_ONE))
		else $error("almost-full flag wrong");

	chk_four_tracks: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
		(!link_diagnostics_write_enable && !wr_txfs && !bus_reset_evt && !tx_fifo_flush
		&& !link_diagnostics_ovr_q) |=> flags_q[2] == $past(free_q >= LBR_FREE_FOUR))
		else $error("four-free flag wrong");

	chk_aempty_tracks: assert property (@(posedge sys_clk) disable iff (sys_rst) // R4
		(!link_diagnostics_write_enable && !wr_txfs && !bus_reset_evt && !tx_fifo_flush
		&& !link_diagnostics_ovr_q) |=> flags_q[3] == $past(fifo_used == LBR_USED_ONE))
		else $error("almost-empty flag wrong");

	chk_empty_tracks: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
		(!link_diagnostics_write_enable && !wr_txfs && !bus_reset_evt && !tx_fifo_flush
		&& !link_diagnostics_ovr_q) |=> flags_q[4] == $past(fifo_used == '0))
		else $error("empty flag wrong");

	// ==========================================================
	// host writes to the flags, with and without diagnostic enable
	chk_flags_ro_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
		(wr_txfs && !link_diagnostics_write_enable && !link_diagnostics_ovr_q && !bus_reset_evt
		&& !tx_fifo_flush) |=> flags_q == $past(flags_d))
		else $error("flag write taken without enable");

	chk_flags_link_diagnostics_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R6
		(wr_txfs && link_diagnostics_write_enable && !bus_reset_evt && !tx_fifo_flush)
		|=> flags_q[0] == $past(reg_wdata[LBR_TX_FULL_BIT]))
		else $error("diagnostic flag write lost");

	// ==========================================================
	// flush request and its effect on the flags
	chk_flush_on_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
		(wr_txfs && reg_wdata[LBR_TX_FLUSH_BIT] && !bus_reset_evt)
		|=> tx_fifo_flush)
		else $error("flush not raised");

	chk_flush_empties: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
		tx_fifo_flush |=> flags_q == 5'b1_0000)
		else $error("flags not empty after flush");

	// ==========================================================
	// host-writable fields take the write; capacity and bus number otherwise hold
	chk_capacity_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
		wr_txfs |=> tx_fifo_capacity == $past(reg_wdata[LBR_TX_CAP_LSB +: CAP_W]))
		else $error("capacity write lost");

	chk_capacity_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
		!wr_txfs |=> $stable(tx_fifo_capacity))
		else $error("capacity changed by itself");

	chk_bus_number_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
		wr_brinfo |=> bus_number == $past(reg_wdata[LBR_BUS_NUMBER_LSB +: 10]))
		else $error("bus number write lost");

	chk_bus_number_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
		!wr_brinfo |=> $stable(bus_number))
		else $error("bus number changed by itself");

	chk_node_host_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
		(wr_brinfo && !phy_selfid_evt && !phy_busreset_evt)
		|=> node_number == $past(reg_wdata[LBR_NODE_NUMBER_LSB +: 6]))
		else $error("node number write lost");

	// ==========================================================
	// topology capture and root mirror
	chk_valid_set: assert property (@(posedge sys_clk) disable iff (sys_rst) // R13
		(topo_valid_evt && !bus_reset_evt) |=> count_resolver_valid_q)
		else $error("valid flag not set");

	chk_count_capture: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
		(topo_valid_evt && !bus_reset_evt)
		|=> node_count_q == $past(topo_node_count))
		else $error("node count not captured");

	chk_resolver_node_id_capture: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
		(topo_valid_evt && !bus_reset_evt)
		|=> resolver_node_id_q == $past(topo_resolver_id))
		else $error("resolver id not captured");

	chk_root_follow: assert property (@(posedge sys_clk) disable iff (sys_rst) // R15
		1'b1 |=> root_q == $past(phy_root))
		else $error("root bit does not follow phy");

	chk_topo_ro_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
		(wr_brinfo && !topo_valid_evt && !bus_reset_evt)
		|=> $stable(node_count_q) && $stable(resolver_node_id_q))
		else $error("read-only topology written");

	// ==========================================================
	// error code holds between events and ignores plain writes
	chk_error_code_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // R21
		(!selfid_err_evt && !wr_bus_reset_error_report) |=> $stable(selfid_error_code))
		else $error("error code changed by itself");

	chk_error_code_ro: assert property (@(posedge sys_clk) disable iff (sys_rst) // R22
		(wr_bus_reset_error_report && !reg_wdata[LBR_ECLR_BIT] && !selfid_err_evt)
		|=> $stable(selfid_error_code))
		else $error("read-only error code written");

	// ==========================================================
	// read data stand only in the slot after the strobe
	chk_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside slot");

	chk_read_txfs_slot: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == LBR_ADDR_TXFS) |=> reg_rdata == $past(txfs_v))
		else $error("fifo status read wrong");

	chk_read_info_slot: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == LBR_ADDR_BRINFO)
		|=> reg_rdata == $past(brinfo_v))
		else $error("node info read wrong");

endmodule

// File: verification/test_link_txfifo_busreset_status_regs.sv
`timescale 1ns/1ps

module test_link_txfifo_busreset_status_regs
	import lbr_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic        sys_clk = 0, sys_rst = 1, bus_reset_evt = 0;
	logic        reg_wr = 0, reg_rd = 0, link_diagnostics_write_enable = 0;
	logic        phy_selfid_evt = 0, phy_busreset_evt = 0;
	logic        topo_valid_evt = 0, phy_root = 0, selfid_err_evt = 0;
	logic [7:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata;
	logic [6:0]  fifo_used = 0, tx_fifo_capacity;
	logic [5:0]  phy_node_id = 0, topo_node_count = 0;
	logic [5:0]  topo_resolver_id = 0, node_number;
	logic [3:0]  selfid_err_in = 0, selfid_error_code;
	logic [9:0]  bus_number;
	logic        tx_fifo_flush;
	int          error_cnt = 0, checks_done = 0;

	lbr_regs i_lbr_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.bus_reset_evt(bus_reset_evt), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link_diagnostics_write_enable(link_diagnostics_write_enable),
		.fifo_used(fifo_used), .tx_fifo_flush(tx_fifo_flush),
		.tx_fifo_capacity(tx_fifo_capacity), .phy_node_id(phy_node_id),
		.phy_selfid_evt(phy_selfid_evt), .phy_busreset_evt(phy_busreset_evt),
		.topo_valid_evt(topo_valid_evt), .topo_node_count(topo_node_count),
		.topo_resolver_id(topo_resolver_id), .phy_root(phy_root),
		.selfid_err_evt(selfid_err_evt), .selfid_err_in(selfid_err_in),
		.bus_number(bus_number), .node_number(node_number),
		.selfid_error_code(selfid_error_code));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// ==========================================================
	// helpers
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task rc(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata, e);
	endtask

	// expected fifo status word from fill level and capacity
	function logic [31:0] txw(input logic [6:0] used, input logic [6:0] cap);
		logic [6:0] fr;
		fr = cap - used;
		txw = {cap, 25'h000_0000};
		txw[0] = (fr == 7'h00);
		txw[1] = (fr == 7'h01);
		txw[4] = (fr >= 7'h04);
		txw[14] = (used == 7'h01);
		txw[15] = (used == 7'h00);
	endfunction

	function logic [31:0] brw(input logic [9:0] bn, input logic [5:0] nn,
		input logic v, input logic [5:0] nc, input logic rt,
		input logic [5:0] ri);
		return {ri, 1'b0, rt, nc, 1'b0, v, nn, bn};
	endfunction

	// ==========================================================
	// scenarios
	task t_reset;
		rc(8'h44, txw(7'h00, 7'h14), "txfs");
		rc(8'h48, brw(10'h3ff, 6'h3f, 0, 6'h01, 0, 6'h3f), "info");
		rc(8'h4c, 32'h0000_0000, "bus_reset_error_report");
		rc(8'h40, 32'h0000_0000, "unmapped");
	endtask

	task t_flags;
		logic [6:0] u [6];
		u = '{7'h14, 7'h13, 7'h10, 7'h0f, 7'h01, 7'h00};
		foreach (u[i])
		begin
			fifo_used <= u[i];
			repeat (2) @(posedge sys_clk);
			rc(8'h44, txw(u[i], 7'h14), "flags");
		end
		wr(8'h44, {7'h14, 25'h000_4013});
		rc(8'h44, txw(7'h00, 7'h14), "ro flags");
		link_diagnostics_write_enable <= 1'b1;
		wr(8'h44, {7'h14, 25'h000_0001});
		rc(8'h44, {7'h14, 25'h000_0001}, "link_diagnostics flags");
		link_diagnostics_write_enable <= 1'b0;
	endtask

	// flush pulses once and the capacity written with it reads back
	task t_flush;
		fifo_used <= 7'h03;
		wr(8'h44, {7'h7f, 25'h002_0000});
		#1 chk("flush", tx_fifo_flush, 1);
		@(posedge sys_clk);
		#1 chk("flush", tx_fifo_flush, 0);
		chk("cap", tx_fifo_capacity, 7'h7f);
		rc(8'h44, txw(7'h03, 7'h7f), "after flush");
		fifo_used <= 7'h00;
		wr(8'h44, {7'h14, 25'h000_0000});
	endtask

	task t_node;
		wr(8'h48, brw(10'h155, 6'h2a, 0, 6'h00, 0, 6'h00));
		#1 chk("bus_number", bus_number, 10'h155);
		chk("node", node_number, 6'h2a);
		@(posedge sys_clk);
		phy_node_id <= 6'h05;
		phy_selfid_evt <= 1'b1;
		@(posedge sys_clk);
		phy_selfid_evt <= 1'b0;
		#1 chk("node phy", node_number, 6'h05);
		phy_busreset_evt <= 1'b1;
		@(posedge sys_clk);
		phy_busreset_evt <= 1'b0;
		#1 chk("node reset", node_number, 6'h3f);
		topo_node_count <= 6'h07;
		topo_resolver_id <= 6'h11;
		phy_root <= 1'b1;
		topo_valid_evt <= 1'b1;
		@(posedge sys_clk);
		topo_valid_evt <= 1'b0;
		rc(8'h48, brw(10'h155, 6'h3f, 1, 6'h07, 1, 6'h11), "topo");
		wr(8'h48, 32'hffff_ffff);
		rc(8'h48, brw(10'h3ff, 6'h3f, 1, 6'h07, 1, 6'h11), "ro info");
		bus_reset_evt <= 1'b1;
		@(posedge sys_clk);
		bus_reset_evt <= 1'b0;
		rc(8'h48, brw(10'h3ff, 6'h3f, 0, 6'h01, 1, 6'h3f), "bus rst");
	endtask

	// each error code from 1 to 8 is latched, then cleared by the host
	task t_err;
		for (int i = 1; i < 9; i++)
		begin
			@(posedge sys_clk);
			selfid_err_in <= i[3:0];
			selfid_err_evt <= 1'b1;
			@(posedge sys_clk);
			selfid_err_evt <= 1'b0;
			rc(8'h4c, {27'h000_0000, i[3:0], 1'b0}, "code");
			wr(8'h4c, 32'h0000_0001);
			rc(8'h4c, 32'h0000_0000, "clear");
		end
	endtask

	task final_report;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset;
		t_flags;
		t_flush;
		t_node;
		t_err;
		final_report;
	end

	initial
	begin
		#50us;
		error_cnt++;
		final_report;
	end
endmodule
